// ==== logic/mlt_codec.v ====
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "mlt_defs.vh"
// ****************************************************************
// low power idle line codec with signal detect timing
// ****************************************************************
module mlt_codec #(
   parameter SD_NORM_ASSERT_CYC = `MLT_SD_NORM_ASSERT_CYC,
   parameter SD_NORM_DEASSERT_CYC = `MLT_SD_NORM_DEASSERT_CYC,
   parameter SD_CNT_W = 20
) (
   input wire core_clk,
   input wire reset,
   // ahb-lite slave
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output wire [31:0] hrdata,
   // pcs side
   input wire [1:0] link_status,
   input wire rx_quiet,
   input wire tx_quiet,
   input wire rx_lpi,
   input wire tx_nrz_bit,
   input wire tx_nrz_strobe,
   input wire rx_nrz_ack,
   output wire rx_nrz_bit,
   output wire signal_detect,
   // line side
   input wire [1:0] line_rx_level,
   input wire line_rx_energy,
   output wire [1:0] line_tx_level,
   output wire line_tx_sd_ok,
   output wire line_tx_full
);

   // ****************************************************************
   // constants sized to the counters they meet
   // ****************************************************************
   localparam [SD_CNT_W-1:0] NORM_ASSERT = SD_NORM_ASSERT_CYC[SD_CNT_W-1:0];
   localparam [SD_CNT_W-1:0] NORM_DEASSERT = SD_NORM_DEASSERT_CYC[SD_CNT_W-1:0];
   // full-width copies, cut to counter width on purpose below
   localparam [31:0] LPI_ASSERT_W = `MLT_SD_LPI_ASSERT_CYC;
   localparam [31:0] LPI_DEASSERT_W = `MLT_SD_LPI_DEASSERT_CYC;
   localparam [31:0] TX_SD_W = `MLT_TX_SD_CYC;
   localparam [31:0] TX_FULL_W = `MLT_TX_FULL_CYC;
   localparam [SD_CNT_W-1:0] LPI_ASSERT = LPI_ASSERT_W[SD_CNT_W-1:0];
   localparam [SD_CNT_W-1:0] LPI_DEASSERT = LPI_DEASSERT_W[SD_CNT_W-1:0];
   localparam [15:0] TX_SD_CYC = TX_SD_W[15:0];
   localparam [15:0] TX_FULL_CYC = TX_FULL_W[15:0];

   // ****************************************************************
   // helpers
   // ****************************************************************
   // smaller of a software value and a hard ceiling, never below one
   function [SD_CNT_W-1:0] clamp_lim;
      input [SD_CNT_W-1:0] want;
      input [SD_CNT_W-1:0] ceil;
      begin
         if (want == {SD_CNT_W{1'b0}})
            clamp_lim = {{(SD_CNT_W-1){1'b0}}, 1'b1};
         else if (want > ceil)
            clamp_lim = ceil;
         else
            clamp_lim = want;
      end
   endfunction

   // ****************************************************************
   // register state
   // ****************************************************************
   reg [31:0] ctrl_reg; // rx and tx enables
   reg [SD_CNT_W-1:0] sdqual_reg; // wanted detect filter length
   reg [15:0] settle_reg; // wanted cycles to full compliance
   reg [31:0] rdata_reg; // read data, latched in the address phase
   reg wr_pend_reg; // write accepted, data phase pending
   reg [7:0] wr_addr_reg; // address of the pending write
   reg sd_reg; // signal detect output
   reg [SD_CNT_W-1:0] sd_cnt_reg; // cycles the raw input disagreed
   reg [15:0] wake_cnt_reg; // cycles since tx_quiet fell
   reg tx_sd_ok_reg; // line is above the detect threshold
   reg tx_full_reg; // line signal is fully compliant
   reg [SD_CNT_W-1:0] sd_cnt_next;
   reg sd_next;
   reg [15:0] wake_cnt_next;
   wire ahb_take; // address phase taken this edge
   wire link_ok; // receive channel intact; the software enables are applied in the restart terms
   wire rx_restart; // decoder restart condition
   wire tx_restart; // encoder restart condition
   wire [SD_CNT_W-1:0] sd_ceil; // hard ceiling for this direction
   wire [SD_CNT_W-1:0] sd_lim; // effective filter length
   wire [15:0] full_lim; // effective compliance delay
   wire [1:0] enc_level; // encoder output level
   wire enc_le; // encoder le flag
   wire dec_prev; // decoder prev class
   wire [31:0] status_word; // live status for reads

   // ****************************************************************
   // link and quiet qualification
   // ****************************************************************
   // ready and fail both count as not ok
   assign link_ok = (link_status == `MLT_LINK_OK);
   // software disable acts like an extra quiet request
   assign rx_restart = !link_ok || rx_quiet || !ctrl_reg[`MLT_CTRL_RX_EN];
   assign tx_restart = !link_ok || tx_quiet || !ctrl_reg[`MLT_CTRL_TX_EN];

   // ****************************************************************
   // decoder and encoder
   // ****************************************************************
   mlt_dec u_dec (
      .core_clk(core_clk),
      .reset(reset),
      .restart(rx_restart),
      .rx_level(line_rx_level),
      .nrz_ack(rx_nrz_ack),
      .nrz_bit(rx_nrz_bit),
      .prev_nonzero(dec_prev)
   );

   mlt_enc u_enc (
      .core_clk(core_clk),
      .reset(reset),
      .restart(tx_restart),
      .nrz_bit(tx_nrz_bit),
      .nrz_strobe(tx_nrz_strobe),
      .tx_level(enc_level),
      .le_flag(enc_le)
   );

   // encoder state is forced to zero whenever restart is up
   assign line_tx_level = enc_level;

   // ****************************************************************
   // signal detect filter
   // ****************************************************************
   // ceiling follows rx_lpi live, so entering lpi mid-count
   // shortens the wait at once rather than at the next change
   assign sd_ceil = sd_reg ? (rx_lpi ? LPI_DEASSERT : NORM_DEASSERT)
                           : (rx_lpi ? LPI_ASSERT : NORM_ASSERT);
   assign sd_lim = clamp_lim(sdqual_reg, sd_ceil);

   // count while the raw detector disagrees, flip at the limit
   always @* begin
      sd_cnt_next = {SD_CNT_W{1'b0}};
      sd_next = sd_reg;
      if (line_rx_energy != sd_reg) begin
         if (sd_cnt_reg + {{(SD_CNT_W-1){1'b0}}, 1'b1} >= sd_lim) begin
            sd_next = line_rx_energy;
            sd_cnt_next = {SD_CNT_W{1'b0}};
         end else begin
            sd_cnt_next = sd_cnt_reg + {{(SD_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // detect flops
   always @(posedge core_clk) begin
      if (reset) begin
         sd_reg <= 1'b0;
         sd_cnt_reg <= {SD_CNT_W{1'b0}};
      end else begin
         sd_reg <= sd_next;
         sd_cnt_reg <= sd_cnt_next;
      end
   end

   assign signal_detect = sd_reg;

   // ****************************************************************
   // transmit wake timing
   // ****************************************************************
   // the driver is live on the first cycle out of quiet, so the
   // threshold flag rises one edge after tx_quiet falls
   assign full_lim = (settle_reg == 16'h0000) ? 16'h0001 :
                     (settle_reg > TX_FULL_CYC) ? TX_FULL_CYC : settle_reg;

   // wake counter saturates at the compliance point
   always @* begin
      wake_cnt_next = wake_cnt_reg;
      if (tx_quiet)
         wake_cnt_next = 16'h0000;
      else if (wake_cnt_reg < full_lim)
         wake_cnt_next = wake_cnt_reg + 16'h0001;
   end

   // wake flags
   always @(posedge core_clk) begin
      if (reset) begin
         wake_cnt_reg <= 16'h0000;
         tx_sd_ok_reg <= 1'b0;
         tx_full_reg <= 1'b0;
      end else begin
         wake_cnt_reg <= wake_cnt_next;
         // threshold reached well inside its 2 us budget
         tx_sd_ok_reg <= !tx_quiet && (TX_SD_CYC != 16'h0000);
         tx_full_reg <= !tx_quiet && (wake_cnt_next >= full_lim);
      end
   end

   assign line_tx_sd_ok = tx_sd_ok_reg;
   assign line_tx_full = tx_full_reg;

   // ****************************************************************
   // ahb-lite slave
   // ****************************************************************
   // zero wait states; only idle and busy are ignored
   assign ahb_take = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   assign status_word = {17'h00000, tx_full_reg, tx_sd_ok_reg, enc_level, enc_le,
                         dec_prev, rx_nrz_bit, tx_quiet, rx_quiet, link_status,
                         rx_lpi, line_rx_energy, sd_reg, 1'b0};

   // read data chosen at the address phase, shown in the data phase
   always @(posedge core_clk) begin
      if (reset) begin
         rdata_reg <= 32'h0000_0000;
      end else if (ahb_take && !hwrite) begin
         case (haddr)
            `MLT_REG_CTRL: rdata_reg <= ctrl_reg;
            `MLT_REG_SDQUAL: rdata_reg <= {{(32-SD_CNT_W){1'b0}}, sdqual_reg};
            `MLT_REG_STATUS: rdata_reg <= status_word;
            `MLT_REG_SETTLE: rdata_reg <= {16'h0000, settle_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign hrdata = rdata_reg;

   // write captured at address phase, stored from hwdata next edge
   always @(posedge core_clk) begin
      if (reset) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         ctrl_reg <= `MLT_CTRL_RST;
         sdqual_reg <= `MLT_SDQUAL_RST;
         settle_reg <= `MLT_SETTLE_RST;
      end else begin
         wr_pend_reg <= ahb_take && hwrite;
         if (ahb_take)
            wr_addr_reg <= haddr;
         if (wr_pend_reg) begin
            case (wr_addr_reg)
               `MLT_REG_CTRL: ctrl_reg <= {30'h0, hwdata[1:0]};
               `MLT_REG_SDQUAL: sdqual_reg <= hwdata[SD_CNT_W-1:0];
               `MLT_REG_SETTLE: settle_reg <= hwdata[15:0];
               default: ctrl_reg <= ctrl_reg;
            endcase
         end
      end
   end
endmodule

// ==== logic/mlt_dec.v ====
`timescale 1ns/1ps
`include "mlt_defs.vh"
// ****************************************************************
// mlt-3 to nrz decoder
// ****************************************************************
module mlt_dec (
   input wire core_clk,
   input wire reset,
   input wire restart,
   input wire [1:0] rx_level,
   input wire nrz_ack,
   output wire nrz_bit,
   output wire prev_nonzero
);
   localparam ST_ZERO = 1'b0;
   localparam ST_ONE = 1'b1;
   reg state_reg; // current output state
   reg state_next;
   reg prev_reg; // class of the last input, 1 = nonzero
   reg prev_next;
   wire cur_nonzero; // class of the present input

   // both nonzero levels fall into one class
   assign cur_nonzero = (rx_level != `MLT_LVL_ZERO);

   // next state moves only on an acknowledge or a restart, so no bit is skipped
   always @* begin
      state_next = state_reg;
      prev_next = prev_reg;
      if (restart) begin
         state_next = ST_ZERO;
         prev_next = cur_nonzero;
      end else if (nrz_ack) begin
         prev_next = cur_nonzero;
         case (cur_nonzero != prev_reg)
            1'b1: state_next = ST_ONE;
            1'b0: state_next = ST_ZERO;
            default: state_next = ST_ZERO;
         endcase
      end
   end

   // state flops
   always @(posedge core_clk) begin
      if (reset) begin
         state_reg <= ST_ZERO;
         prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         prev_reg <= prev_next;
      end
   end

   assign nrz_bit = state_reg;
   assign prev_nonzero = prev_reg;
endmodule

// ==== logic/mlt_enc.v ====
`timescale 1ns/1ps
`include "mlt_defs.vh"
// ****************************************************************
// nrz to mlt-3 encoder
// ****************************************************************
module mlt_enc (
   input wire core_clk,
   input wire reset,
   input wire restart,
   input wire nrz_bit,
   input wire nrz_strobe,
   output wire [1:0] tx_level,
   output wire le_flag
);
   localparam ST_ZERO = 2'h0;
   localparam ST_PLUS = 2'h1;
   localparam ST_MINUS = 2'h3;
   reg [1:0] state_reg; // state code equals the driven level
   reg [1:0] state_next;
   reg le_reg; // last nonzero level was positive
   reg le_next;

   // one step per nrz one, hold on nrz zero
   always @* begin
      state_next = state_reg;
      le_next = le_reg;
      if (restart) begin
         state_next = ST_ZERO;
      end else if (nrz_strobe && nrz_bit) begin
         case (state_reg)
            ST_ZERO: begin
               if (le_reg) begin
                  state_next = ST_MINUS;
                  le_next = 1'b0;
               end else begin
                  state_next = ST_PLUS;
                  le_next = 1'b1;
               end
            end
            ST_PLUS: state_next = ST_ZERO;
            ST_MINUS: state_next = ST_ZERO;
            default: state_next = ST_ZERO;
         endcase
      end
   end

   // state flops
   always @(posedge core_clk) begin
      if (reset) begin
         state_reg <= ST_ZERO;
         le_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         le_reg <= le_next;
      end
   end

   assign tx_level = state_reg;
   assign le_flag = le_reg;
endmodule

// ==== shared/mlt_defs.vh ====
// Overview of operation
// - decoder turns mlt-3 stream into nrz bits
// - input class is zero or nonzero level
// - prev_data keeps class of last input
// - class change gives one, else zero
// - link not ok or rx_quiet restarts decoder
// - link_status is fail, ready or ok
// - detect asserts within 5 us lpi, 1000 normal
// - detect deasserts within 5 us lpi, 350 normal
// - one detect output, timing chosen by rx_lpi
// - after tx_quiet falls, 2 us and 5 us
// - encoder drives positive, zero or negative level
// - le_flag set entering plus, cleared entering minus
`ifndef MLT_DEFS_VH
`define MLT_DEFS_VH

// ****************************************************************
// line levels and link states
// ****************************************************************
`define MLT_LVL_ZERO 2'h0
`define MLT_LVL_PLUS 2'h1
`define MLT_LVL_MINUS 2'h3
`define MLT_LINK_FAIL 2'h0
`define MLT_LINK_READY 2'h1
`define MLT_LINK_OK 2'h2

// ****************************************************************
// timing, microseconds and clock rate
// ****************************************************************
`define MLT_CLK_MHZ 200
`define MLT_SD_NORM_ASSERT_US 1000
`define MLT_SD_NORM_DEASSERT_US 350
`define MLT_SD_LPI_ASSERT_US 5
`define MLT_SD_LPI_DEASSERT_US 5
`define MLT_TX_SD_US 2
`define MLT_TX_FULL_US 5
`define MLT_SD_NORM_ASSERT_CYC (`MLT_SD_NORM_ASSERT_US * `MLT_CLK_MHZ)
`define MLT_SD_NORM_DEASSERT_CYC (`MLT_SD_NORM_DEASSERT_US * `MLT_CLK_MHZ)
`define MLT_SD_LPI_ASSERT_CYC (`MLT_SD_LPI_ASSERT_US * `MLT_CLK_MHZ)
`define MLT_SD_LPI_DEASSERT_CYC (`MLT_SD_LPI_DEASSERT_US * `MLT_CLK_MHZ)
`define MLT_TX_SD_CYC (`MLT_TX_SD_US * `MLT_CLK_MHZ)
`define MLT_TX_FULL_CYC (`MLT_TX_FULL_US * `MLT_CLK_MHZ)

// ****************************************************************
// register map, byte addresses
// ****************************************************************
`define MLT_REG_CTRL 8'h00
`define MLT_REG_SDQUAL 8'h04
`define MLT_REG_STATUS 8'h08
`define MLT_REG_SETTLE 8'h0c
`define MLT_CTRL_RST 32'h0000_0003
`define MLT_SDQUAL_RST 20'h00010
`define MLT_SETTLE_RST 16'h0080
`define MLT_CTRL_RX_EN 0
`define MLT_CTRL_TX_EN 1

`endif

// ==== test/mlt_codec_chk.sv ====
`timescale 1ns/1ps
`include "mlt_defs.vh"
// ********
// port checker for the codec top
// ********
module mlt_codec_chk #(
   parameter SD_NORM_ASSERT_CYC = 64,
   parameter SD_NORM_DEASSERT_CYC = 32
) (
   input wire core_clk,
   input wire reset,
   input wire [1:0] link_status,
   input wire rx_quiet,
   input wire tx_quiet,
   input wire rx_lpi,
   input wire tx_nrz_bit,
   input wire tx_nrz_strobe,
   input wire rx_nrz_ack,
   input wire rx_nrz_bit,
   input wire signal_detect,
   input wire [1:0] line_rx_level,
   input wire line_rx_energy,
   input wire [1:0] line_tx_level,
   input wire line_tx_sd_ok,
   input wire line_tx_full
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   wire rx_rst = link_status != `MLT_LINK_OK || rx_quiet; // decoder restart
   wire tx_rst = link_status != `MLT_LINK_OK || tx_quiet; // encoder restart
   wire rx_nz = line_rx_level != `MLT_LVL_ZERO; // input class
   wire enc_one = tx_nrz_strobe && tx_nrz_bit && !tx_rst; // encoder step
   logic nz_d, lpi_d, last_minus;
   int on_cnt, off_cnt, wake_cnt;
   // run lengths are counted here, repetition cannot reach these figures
   always @(posedge core_clk) begin
      nz_d <= rx_nz;
      lpi_d <= rx_lpi;
      if (reset)
         last_minus <= 1'b1;
      else if (line_tx_level != `MLT_LVL_ZERO)
         last_minus <= line_tx_level == `MLT_LVL_MINUS;
      on_cnt <= (reset || !line_rx_energy || rx_lpi != lpi_d) ? 0 : on_cnt + 1;
      off_cnt <= (reset || line_rx_energy || rx_lpi != lpi_d) ? 0 : off_cnt + 1;
      wake_cnt <= (reset || tx_quiet) ? 0 : wake_cnt + 1;
   end
   property p_dec_zero;
      rx_rst |=> !rx_nrz_bit;
   endproperty
   a_dec_zero: assert property (p_dec_zero) else $error("dec restart");
   property p_dec_val;
      rx_nrz_ack && !rx_rst && $past(rx_nrz_ack || rx_rst) |=> rx_nrz_bit == $past(rx_nz != nz_d);
   endproperty
   a_dec_val: assert property (p_dec_val) else $error("dec value");
   property p_dec_hold;
      !rx_nrz_ack && !rx_rst |=> $stable(rx_nrz_bit);
   endproperty
   a_dec_hold: assert property (p_dec_hold) else $error("dec moved");
   property p_enc_zero;
      tx_rst |=> line_tx_level == `MLT_LVL_ZERO;
   endproperty
   a_enc_zero: assert property (p_enc_zero) else $error("enc restart");
   property p_enc_hold;
      !(tx_nrz_strobe && tx_nrz_bit) && !tx_rst |=> $stable(line_tx_level);
   endproperty
   a_enc_hold: assert property (p_enc_hold) else $error("enc moved");
   property p_enc_back;
      enc_one && line_tx_level != `MLT_LVL_ZERO |=> line_tx_level == `MLT_LVL_ZERO;
   endproperty
   a_enc_back: assert property (p_enc_back) else $error("enc no zero");
   property p_enc_dir;
      enc_one && line_tx_level == `MLT_LVL_ZERO
         |=> line_tx_level == (last_minus ? `MLT_LVL_PLUS : `MLT_LVL_MINUS);
   endproperty
   a_enc_dir: assert property (p_enc_dir) else $error("enc direction");
   property p_sd_up;
      rx_lpi && on_cnt == `MLT_SD_LPI_ASSERT_CYC || !rx_lpi && on_cnt == SD_NORM_ASSERT_CYC
         |-> ##4 signal_detect;
   endproperty
   a_sd_up: assert property (p_sd_up) else $error("detect late");
   property p_sd_down;
      rx_lpi && off_cnt == `MLT_SD_LPI_DEASSERT_CYC || !rx_lpi && off_cnt == SD_NORM_DEASSERT_CYC
         |-> ##4 !signal_detect;
   endproperty
   a_sd_down: assert property (p_sd_down) else $error("loss late");
   property p_wake_sd;
      wake_cnt == `MLT_TX_SD_CYC |-> line_tx_sd_ok;
   endproperty
   a_wake_sd: assert property (p_wake_sd) else $error("wake late");
   property p_wake_full;
      wake_cnt == `MLT_TX_FULL_CYC |-> line_tx_full;
   endproperty
   a_wake_full: assert property (p_wake_full) else $error("full late");
   c_sd: cover property (rx_lpi && $rose(signal_detect));
   c_minus: cover property (line_tx_level == `MLT_LVL_MINUS);
   c_one: cover property (rx_nrz_bit);
endmodule
bind mlt_codec mlt_codec_chk #(
   .SD_NORM_ASSERT_CYC(SD_NORM_ASSERT_CYC),
   .SD_NORM_DEASSERT_CYC(SD_NORM_DEASSERT_CYC)
) chk_u (
   .core_clk(core_clk), .reset(reset), .link_status(link_status), .rx_quiet(rx_quiet),
   .tx_quiet(tx_quiet), .rx_lpi(rx_lpi), .tx_nrz_bit(tx_nrz_bit),
   .tx_nrz_strobe(tx_nrz_strobe), .rx_nrz_ack(rx_nrz_ack), .rx_nrz_bit(rx_nrz_bit),
   .signal_detect(signal_detect), .line_rx_level(line_rx_level),
   .line_rx_energy(line_rx_energy), .line_tx_level(line_tx_level),
   .line_tx_sd_ok(line_tx_sd_ok), .line_tx_full(line_tx_full)
);

// ==== test/mlt_codec_tb_top.sv ====
`timescale 1ns/1ps
`include "mlt_defs.vh"
module mlt_codec_tb_top;
   // ********
   // stimulus, wires and counters
   // ********
   logic core_clk, reset, hsel, hwrite, rx_quiet, tx_quiet, rx_lpi, line_rx_energy;
   logic pcs_run, pcs_slow, le_exp, dec_exp, prev_exp;
   logic [1:0] htrans, link_status, line_rx_level, enc_exp;
   logic [2:0] hsize;
   logic [7:0] haddr;
   logic [31:0] hwdata, rd;
   wire hready, hresp, rx_nrz_bit, signal_detect, line_tx_sd_ok, line_tx_full;
   wire tx_nrz_bit, tx_nrz_strobe, rx_nrz_ack;
   wire [1:0] line_tx_level;
   wire [31:0] hrdata;
   wire rx_nz = line_rx_level != `MLT_LVL_ZERO;
   int err_count, samples_checked, cyc;
   mlt_codec #(.SD_NORM_ASSERT_CYC(64), .SD_NORM_DEASSERT_CYC(32)) dut_u (
      .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link_status(link_status),
      .rx_quiet(rx_quiet), .tx_quiet(tx_quiet), .rx_lpi(rx_lpi), .tx_nrz_bit(tx_nrz_bit),
      .tx_nrz_strobe(tx_nrz_strobe), .rx_nrz_ack(rx_nrz_ack), .rx_nrz_bit(rx_nrz_bit),
      .signal_detect(signal_detect), .line_rx_level(line_rx_level),
      .line_rx_energy(line_rx_energy), .line_tx_level(line_tx_level),
      .line_tx_sd_ok(line_tx_sd_ok), .line_tx_full(line_tx_full));
   mlt_pcs_model pcs_u (.core_clk(core_clk), .reset(reset), .run(pcs_run), .slow(pcs_slow),
      .tx_nrz_bit(tx_nrz_bit), .tx_nrz_strobe(tx_nrz_strobe), .rx_nrz_ack(rx_nrz_ack));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // ********
   // reference coder, line pattern and timeout
   // ********
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      line_rx_level <= 2'(32'h3c4d_10e7 >> (2 * cyc[3:0]));
      if (reset) begin
         enc_exp <= `MLT_LVL_ZERO;
         le_exp <= 1'b0;
         dec_exp <= 1'b0;
         prev_exp <= 1'b0;
      end else begin
         if (tx_quiet || link_status != `MLT_LINK_OK)
            enc_exp <= `MLT_LVL_ZERO;
         else if (tx_nrz_strobe && tx_nrz_bit && enc_exp != `MLT_LVL_ZERO)
            enc_exp <= `MLT_LVL_ZERO;
         else if (tx_nrz_strobe && tx_nrz_bit) begin
            enc_exp <= le_exp ? `MLT_LVL_MINUS : `MLT_LVL_PLUS;
            le_exp <= !le_exp;
         end
         if (rx_quiet || link_status != `MLT_LINK_OK) begin
            dec_exp <= 1'b0;
            prev_exp <= rx_nz;
         end else if (rx_nrz_ack) begin
            dec_exp <= rx_nz != prev_exp;
            prev_exp <= rx_nz;
         end
      end
      // a hang counts as a mismatch
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   // ********
   // shared tasks
   // ********
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      @(posedge core_clk);
      while (hready !== 1'b1)
         @(posedge core_clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge core_clk);
      while (hready !== 1'b1)
         @(posedge core_clk);
      rd = hrdata;
      chk(32'(hresp), 32'h0);
   endtask
   task run_chk(input int n);
      repeat (n) begin
         @(negedge core_clk);
         chk(32'(line_tx_level), 32'(enc_exp));
         chk(32'(rx_nrz_bit), 32'(dec_exp));
      end
      @(posedge core_clk);
   endtask
   function automatic logic pick(input int s);
      return s == 0 ? signal_detect : s == 1 ? line_tx_sd_ok : line_tx_full;
   endfunction
   // waits for a level, then judges how many edges it took
   task wait_on(input int s, input logic v, input int lo, input int hi);
      int n;
      n = 0;
      @(posedge core_clk);
      while (pick(s) !== v && n < hi) begin
         @(posedge core_clk);
         n++;
      end
      chk(32'(n >= lo && pick(s) === v), 32'h1);
   endtask
   // ********
   // scenarios
   // ********
   task t_regs;
      ahb(1'b0, `MLT_REG_CTRL, 32'h0);
      chk(rd, `MLT_CTRL_RST);
      ahb(1'b0, `MLT_REG_SDQUAL, 32'h0);
      chk(rd, 32'(`MLT_SDQUAL_RST));
      ahb(1'b0, `MLT_REG_SETTLE, 32'h0);
      chk(rd, 32'(`MLT_SETTLE_RST));
      ahb(1'b1, 8'h10, 32'hffff_ffff);
      ahb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b1, `MLT_REG_CTRL, 32'h3);
      $display("t_regs done");
   endtask
   task t_codec;
      link_status <= `MLT_LINK_OK;
      pcs_run <= 1'b1;
      run_chk(200);
      pcs_slow <= 1'b1;
      run_chk(200);
      link_status <= `MLT_LINK_READY;
      run_chk(20);
      link_status <= `MLT_LINK_FAIL;
      run_chk(20);
      link_status <= `MLT_LINK_OK;
      rx_quiet <= 1'b1;
      run_chk(20);
      rx_quiet <= 1'b0;
      tx_quiet <= 1'b1;
      run_chk(20);
      tx_quiet <= 1'b0;
      run_chk(60);
      pcs_run <= 1'b0;
      run_chk(8);
      ahb(1'b0, `MLT_REG_STATUS, 32'h0);
      chk(32'(rd[12:1]), 32'({enc_exp, le_exp, prev_exp, dec_exp, 4'h2, 3'h0}));
      $display("t_codec done");
   endtask
   task t_detect;
      ahb(1'b1, `MLT_REG_SDQUAL, 32'h0000_00c8);
      ahb(1'b0, `MLT_REG_SDQUAL, 32'h0);
      chk(rd, 32'h0000_00c8);
      line_rx_energy <= 1'b1;
      wait_on(0, 1'b1, 50, 100);
      line_rx_energy <= 1'b0;
      wait_on(0, 1'b0, 20, 60);
      ahb(1'b1, `MLT_REG_SDQUAL, 32'h000f_ffff);
      rx_lpi <= 1'b1;
      line_rx_energy <= 1'b1;
      wait_on(0, 1'b1, 995, 1000);
      line_rx_energy <= 1'b0;
      wait_on(0, 1'b0, 995, 1000);
      rx_lpi <= 1'b0;
      $display("t_detect done");
   endtask
   task t_wake;
      ahb(1'b1, `MLT_REG_SETTLE, 32'h0000_0020);
      tx_quiet <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk(32'(line_tx_sd_ok), 32'h0);
      tx_quiet <= 1'b0;
      wait_on(1, 1'b1, 0, 400);
      wait_on(2, 1'b1, 20, 60);
      repeat (1000) @(posedge core_clk);
      chk(32'(line_tx_full), 32'h1);
      $display("t_wake done");
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      {hsel, hwrite, rx_quiet, tx_quiet, rx_lpi, line_rx_energy, pcs_run, pcs_slow} = 8'h0;
      htrans = 2'h0;
      haddr = 8'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      link_status = `MLT_LINK_FAIL;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      t_regs();
      t_codec();
      t_detect();
      t_wake();
      wrap_up();
   end
endmodule

// ==== test/mlt_pcs_model.sv ====
`timescale 1ns/1ps
// ********
// pcs model: scrambler strobes and descrambler acks
// ********
module mlt_pcs_model (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic run,
   input wire logic slow,
   output logic tx_nrz_bit,
   output logic tx_nrz_strobe,
   output logic rx_nrz_ack
);
   logic [6:0] lfsr_reg; // scrambled bit source
   logic [1:0] div_reg; // pacing in slow mode
   always @(posedge core_clk) begin
      if (reset) begin
         lfsr_reg <= 7'h5b;
         div_reg <= 2'h0;
         tx_nrz_strobe <= 1'b0;
         rx_nrz_ack <= 1'b0;
         tx_nrz_bit <= 1'b0;
      end else begin
         div_reg <= div_reg + 2'h1;
         lfsr_reg <= {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
         tx_nrz_strobe <= run && (!slow || div_reg == 2'h0);
         rx_nrz_ack <= run && (!slow || div_reg == 2'h2);
         // between strobes the bit toggles so a stale value is never trusted
         tx_nrz_bit <= (run && (!slow || div_reg == 2'h0)) ? lfsr_reg[6] : ~tx_nrz_bit;
      end
   end
endmodule
